// ==== flash_port_pkg.sv ====
// constants and carrier types for the serial flash host port
// assumes a single reference clock domain; the serial pins are asynchronous
`default_nettype none
package flash_port_pkg;
   // ***************************************
   // geometry
   // ***************************************
   localparam int PAGE_BYTES_STD = 512;
   localparam int PAGE_BYTES_EXT = 528;
   localparam int PAGE_COUNT = 4096;
   localparam int PAGE_AW = 12;
   localparam int OFS_W = 10;
   localparam int BUF_COUNT = 2;
   localparam int ADDR_BYTES = 3;
   localparam int OPC_W = 8;
   // page field positions inside the 24-bit address, per page size
   localparam int EXT_PAGE_LSB = 10;
   localparam int STD_PAGE_LSB = 9;
   // ***************************************
   // reset values and timing
   // ***************************************
   localparam logic PAGE_528_RESET = 1'b1;
   localparam int REF_CLK_HZ = 20_000_000;
   localparam int FIFO_DEPTH_DEF = 16;
   // ***************************************
   // command codes (values are arbitrary)
   // ***************************************
   localparam logic [7:0] OPC_WRITE_BUF0 = 8'h10;
   localparam logic [7:0] OPC_WRITE_BUF1 = 8'h11;
   localparam logic [7:0] OPC_READ_BUF0 = 8'h20;
   localparam logic [7:0] OPC_READ_BUF1 = 8'h21;
   localparam logic [7:0] OPC_PROG_BUF0 = 8'h30;
   localparam logic [7:0] OPC_PROG_BUF1 = 8'h31;
   localparam logic [7:0] OPC_CFG_512 = 8'h40;
   localparam logic [7:0] OPC_CFG_528 = 8'h41;
   // ***************************************
   // types
   // ***************************************
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_OPCODE = 2'b01,
      ST_ADDR = 2'b11,
      ST_DATA = 2'b10
   } frame_state_type;
   typedef struct packed
   {
      logic buf_sel;
      logic [OFS_W-1:0] offset;
      logic [7:0] data;
   } wr_word_type;
   typedef struct packed
   {
      logic start;
      logic buf_sel;
      logic [PAGE_AW-1:0] page;
   } prog_req_type;
endpackage
`default_nettype wire

// ==== flash_host_port.sv ====
// serial slave front end of a paged flash: pin sampling, framing, buffers
// assumes cs, sck and si come from another domain; sck far below ref_clk/4
`default_nettype none

// ***************************************
// word fifo
// ***************************************
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] in_data_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   output logic [WIDTH-1:0] out_data_out,
   output logic out_valid_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign in_ready_out = (count_r != (AW+1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out = mem_r[rd_ptr_r];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_ff @(posedge ref_clk_in)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module flash_host_port
   import flash_port_pkg::*;
#(
   parameter int PAGE_MAX = PAGE_BYTES_EXT,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter int PROG_TIME_NS = 2_000_000
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic sck_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_n_out,
   output logic busy_out,
   output logic standby_out,
   output logic page_528_out,
   output logic overrun_out,
   output prog_req_type prog_out
);
   // count from whole microseconds, rounded down, at least one cycle
   localparam int PROG_CYCLES_RAW = (PROG_TIME_NS / 1000) * (REF_CLK_HZ / 1_000_000);
   localparam int PROG_CYCLES = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;

   // ***************************************
   // pin synchronisers and edges
   // ***************************************
   logic cs_meta_r, cs_s_r, cs_d_r;
   logic sck_meta_r, sck_s_r, sck_d_r;
   logic si_meta_r, si_s_r;
   logic cs_fall, cs_rise, sck_rise, sck_fall;

   // sck rate bound
   // edges are found by oversampling, so sck must stay below ref_clk/4
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         cs_meta_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         sck_meta_r <= 1'b0;
         sck_s_r <= 1'b0;
         sck_d_r <= 1'b0;
         si_meta_r <= 1'b0;
         si_s_r <= 1'b0;
      end
      else
      begin
         cs_meta_r <= cs_n_in;
         cs_s_r <= cs_meta_r;
         cs_d_r <= cs_s_r;
         sck_meta_r <= sck_in;
         sck_s_r <= sck_meta_r;
         sck_d_r <= sck_s_r;
         si_meta_r <= si_in;
         si_s_r <= si_meta_r;
      end
   end

   assign cs_fall = cs_d_r & ~cs_s_r;
   assign cs_rise = ~cs_d_r & cs_s_r;
   // idle level of sck is irrelevant; only edges inside a frame count
   assign sck_rise = sck_s_r & ~sck_d_r;
   assign sck_fall = ~sck_s_r & sck_d_r;

   // ***************************************
   // framing and shifting
   // ***************************************
   frame_state_type state_r;
   logic [6:0] shift_r;
   logic [2:0] bit_cnt_r;
   logic [1:0] addr_cnt_r;
   logic [OPC_W-1:0] opc_r;
   logic [15:0] addr_hi_r;
   logic [7:0] byte_val;
   logic byte_done;
   logic [23:0] addr_full;
   logic is_write, is_read, is_prog, is_cfg;
   logic buf_sel;
   logic page_528_r;
   logic [PAGE_AW-1:0] page_r;
   logic [OFS_W-1:0] start_ofs, ofs_r, ofs_inc;

   assign byte_val = {shift_r, si_s_r};
   assign byte_done = sck_rise & (state_r != ST_IDLE) & (bit_cnt_r == 3'd7);
   assign addr_full = {addr_hi_r, byte_val};
   assign is_write = (opc_r == OPC_WRITE_BUF0) | (opc_r == OPC_WRITE_BUF1);
   assign is_read = (opc_r == OPC_READ_BUF0) | (opc_r == OPC_READ_BUF1);
   assign is_prog = (opc_r == OPC_PROG_BUF0) | (opc_r == OPC_PROG_BUF1);
   assign is_cfg = (opc_r == OPC_CFG_512) | (opc_r == OPC_CFG_528);
   assign buf_sel = opc_r[0];
   // offset field width follows page size
   assign start_ofs = page_528_r ? addr_full[OFS_W-1:0] : {1'b0, addr_full[OFS_W-2:0]};
   assign ofs_inc = (32'(ofs_r) == (page_528_r ? PAGE_BYTES_EXT : PAGE_BYTES_STD) - 1)
                    ? '0 : ofs_r + 1'b1;

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in | cs_rise)
      begin
         state_r <= ST_IDLE;
         addr_cnt_r <= '0;
      end
      else if (cs_fall)
      begin
         state_r <= ST_OPCODE;
         addr_cnt_r <= '0;
      end
      else if (byte_done)
      begin
         unique case (state_r)
            ST_OPCODE:
            begin
               state_r <= ((byte_val == OPC_CFG_512) | (byte_val == OPC_CFG_528))
                          ? ST_DATA : ST_ADDR;
            end
            ST_ADDR:
            begin
               addr_cnt_r <= addr_cnt_r + 1'b1;
               if (addr_cnt_r == 2'(ADDR_BYTES - 1))
               begin
                  state_r <= ST_DATA;
               end
            end
            ST_DATA:
            begin
               state_r <= ST_DATA;
            end
            ST_IDLE:
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         shift_r <= '0;
         bit_cnt_r <= '0;
         opc_r <= '0;
         addr_hi_r <= '0;
      end
      else if (cs_fall)
      begin
         bit_cnt_r <= '0;
      end
      else if (sck_rise & (state_r != ST_IDLE))
      begin
         shift_r <= byte_val[6:0];
         bit_cnt_r <= bit_cnt_r + 1'b1;
         if (byte_done & (state_r == ST_OPCODE))
         begin
            opc_r <= byte_val;
         end
         if (byte_done & (state_r == ST_ADDR))
         begin
            addr_hi_r <= {addr_hi_r[7:0], byte_val};
         end
      end
   end

   // ***************************************
   // buffers, write path and read path
   // ***************************************
   logic [7:0] buf_mem_r [BUF_COUNT][PAGE_MAX];
   wr_word_type push_word, pop_word;
   logic push_valid, push_ready, pop_valid, pop_ready;
   logic busy_r, busy_buf_r, overrun_r;
   logic [7:0] out_sh_r;
   logic [2:0] out_cnt_r;
   logic so_r, rd_active, addr_last;

   assign addr_last = byte_done & (state_r == ST_ADDR) & (addr_cnt_r == 2'(ADDR_BYTES - 1));
   assign rd_active = (state_r == ST_DATA) & is_read;
   assign push_word = '{buf_sel: buf_sel, offset: ofs_r, data: byte_val};
   assign push_valid = byte_done & (state_r == ST_DATA) & is_write;
   // only the buffer under programming holds the drain
   assign pop_ready = ~(busy_r & (pop_word.buf_sel == busy_buf_r));

   word_fifo #(
      .WIDTH($bits(wr_word_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .in_data_in(push_word),
      .in_valid_in(push_valid),
      .in_ready_out(push_ready),
      .out_data_out(pop_word),
      .out_valid_out(pop_valid),
      .out_ready_in(pop_ready)
   );

   always_ff @(posedge ref_clk_in)
   begin
      if (pop_valid & pop_ready)
      begin
         buf_mem_r[pop_word.buf_sel][pop_word.offset] <= pop_word.data;
      end
   end

   // set wins over the clear at frame start
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         overrun_r <= 1'b0;
      end
      else if (push_valid & ~push_ready)
      begin
         overrun_r <= 1'b1;
      end
      else if (cs_fall)
      begin
         overrun_r <= 1'b0;
      end
   end

   // output moves on falling sck only
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         ofs_r <= '0;
         out_sh_r <= '0;
         out_cnt_r <= '0;
         so_r <= 1'b0;
      end
      // a page size change must not leave the offset past the page end
      else if (cs_rise)
      begin
         ofs_r <= '0;
      end
      else if (addr_last)
      begin
         ofs_r <= start_ofs;
         out_sh_r <= buf_mem_r[buf_sel][start_ofs];
         out_cnt_r <= '0;
      end
      else if (push_valid)
      begin
         ofs_r <= ofs_inc;
      end
      else if (sck_fall & rd_active)
      begin
         so_r <= out_sh_r[7];
         out_cnt_r <= out_cnt_r + 1'b1;
         if (out_cnt_r == 3'd7)
         begin
            ofs_r <= ofs_inc;
            out_sh_r <= buf_mem_r[buf_sel][ofs_inc];
         end
         else
         begin
            out_sh_r <= {out_sh_r[6:0], 1'b0};
         end
      end
   end

   // raw pin releases the line at once
   assign so_oe_n_out = cs_n_in | cs_s_r | ~rd_active;
   assign so_out = so_r;

   // ***************************************
   // self-timed program, config, standby
   // ***************************************
   logic [31:0] busy_cnt_r;
   logic standby_r;
   logic prog_go;
   prog_req_type prog_r;

   assign prog_go = cs_rise & (state_r == ST_DATA) & is_prog & ~busy_r;

   // page field taken from the address
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         page_r <= '0;
      end
      else if (addr_last)
      begin
         page_r <= page_528_r ? addr_full[EXT_PAGE_LSB +: PAGE_AW]
                              : addr_full[STD_PAGE_LSB +: PAGE_AW];
      end
   end

   // countdown on ref_clk, no sck needed
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         busy_r <= 1'b0;
         busy_buf_r <= 1'b0;
         busy_cnt_r <= '0;
         prog_r <= '0;
      end
      else
      begin
         prog_r <= '{start: prog_go, buf_sel: buf_sel, page: page_r};
         if (prog_go)
         begin
            busy_r <= 1'b1;
            busy_buf_r <= buf_sel;
            busy_cnt_r <= 32'(PROG_CYCLES - 1);
         end
         else if (busy_r)
         begin
            busy_cnt_r <= busy_cnt_r - 1'b1;
            busy_r <= (busy_cnt_r != '0);
         end
      end
   end

   // page size changes at frame end
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         page_528_r <= PAGE_528_RESET;
      end
      else if (cs_rise & (state_r == ST_DATA) & is_cfg)
      begin
         page_528_r <= (opc_r == OPC_CFG_528);
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         standby_r <= 1'b0;
      end
      else
      begin
         // a program launched at frame end must not let standby flash up for one cycle
         standby_r <= cs_s_r & ~busy_r & ~prog_go;
      end
   end

   assign busy_out = busy_r;
   assign standby_out = standby_r;
   assign page_528_out = page_528_r;
   assign overrun_out = overrun_r;
   assign prog_out = prog_r;

   // ***************************************
   // checks
   // ***************************************
   a_so_released: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cs_s_r |-> so_oe_n_out) else $error("output driven while deselected");
   a_idle_no_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (cs_s_r && $past(cs_s_r)) |=> $stable(shift_r)) else $error("bit captured while idle");
   a_frame_opens: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cs_fall |=> (state_r == ST_OPCODE)) else $error("frame start missed");
   a_sample_on_rise: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (bit_cnt_r != $past(bit_cnt_r)) && !$past(cs_fall) |-> $past(sck_rise))
      else $error("bit counted without rising sck");
   a_so_on_fall: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $changed(so_r) |-> $past(sck_fall)) else $error("output moved off falling sck");
   a_opcode_msb: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (byte_done && state_r == ST_OPCODE) |=> (opc_r == $past(byte_val)))
      else $error("opcode not assembled msb first");
   a_busy_holds: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      prog_go |=> busy_r [*8]) else $error("program ended too early");
   a_standby_wait: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      busy_r |=> !standby_r) else $error("standby entered while busy");
   a_standby_entry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (cs_s_r && !busy_r) [*2] |-> standby_r) else $error("standby not entered");
   a_ofs_in_page: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      32'(ofs_r) < (page_528_r ? PAGE_BYTES_EXT : PAGE_BYTES_STD))
      else $error("offset beyond page");
   a_drain_free: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (pop_valid && (!busy_r || pop_word.buf_sel != busy_buf_r)) |-> pop_ready)
      else $error("free buffer drain stalled");
endmodule
`default_nettype wire

// ==== host_model.sv ====
// host side model: drives the serial pins of the flash port
// assumes the 50 ns bench clock; half an sck period is 4 cycles
`default_nettype none
module host_model (
   input wire logic ref_clk_in,
   input wire logic so_in,
   input wire logic so_oe_n_in,
   output logic cs_n_out,
   output logic sck_out,
   output logic si_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_r = 1'b0;
   logic so_line;
   initial
   begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
   end
   // ***************************************
   // released output line
   // ***************************************
   always @(posedge ref_clk_in)
   begin
      if (!so_oe_n_in)
      begin
         last_r <= so_in;
      end
   end
   // no pull on the line: released so reads as the inverse
   assign so_line = so_oe_n_in ? ~last_r : so_in;
   // ***************************************
   // link tasks
   // ***************************************
   // 400 ns period
   task automatic half();
      repeat (4) @(posedge ref_clk_in);
   endtask
   task automatic start_frame(input logic mode3);
      @(posedge ref_clk_in);
      sck_out <= mode3;
      half();
      cs_n_out <= 1'b0;
      half();
   endtask
   // msb first, bit set half a period before rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         sck_out <= 1'b0;
         si_out <= tx[i];
         half();
         rx[i] = so_line;
         sck_out <= 1'b1;
         half();
      end
   endtask
   task automatic end_frame(input logic mode3);
      if (!mode3)
      begin
         sck_out <= 1'b0;
      end
      half();
      cs_n_out <= 1'b1;
      si_out <= ~si_out;
      half();
   endtask
   // traffic while deselected, only when a scenario asks
   task automatic noise(input int n);
      for (int i = 0; i < n; i++)
      begin
         sck_out <= ~sck_out;
         si_out <= i[1];
         half();
      end
   endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the flash host port
// assumes host_model on the pins and a short program time
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_port_pkg::*;
   localparam int PROG_NS = 150_000;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, sck, si, so, so_oe_n, busy, standby, page_528, overrun;
   prog_req_type prog;
   prog_req_type last_prog = '0;
   logic [7:0] n_start = 8'h00;
   int miscompares = 0;
   int n_checks = 0;
   initial
   begin
      forever #25 ref_clk = ~ref_clk;
   end
   flash_host_port #(.PROG_TIME_NS(PROG_NS)) flash_host_port_inst (
      .ref_clk_in(ref_clk),
      .rst_in(rst),
      .cs_n_in(cs_n),
      .sck_in(sck),
      .si_in(si),
      .so_out(so),
      .so_oe_n_out(so_oe_n),
      .busy_out(busy),
      .standby_out(standby),
      .page_528_out(page_528),
      .overrun_out(overrun),
      .prog_out(prog)
   );
   host_model host_model_inst (
      .ref_clk_in(ref_clk),
      .so_in(so),
      .so_oe_n_in(so_oe_n),
      .cs_n_out(cs_n),
      .sck_out(sck),
      .si_out(si)
   );
   // start pulses are too short for the frame tasks to see
   always @(posedge ref_clk)
   begin
      if (prog.start === 1'b1)
      begin
         last_prog <= prog;
         n_start <= n_start + 8'h01;
      end
   end
   // ***************************************
   // checking
   // ***************************************
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      cmp({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp({8'h00, got}, {8'h00, exp});
   endtask
   task automatic chk_prog(input prog_req_type got, input prog_req_type exp);
      cmp({2'b00, got}, {2'b00, exp});
   endtask
   // bounded wait on one output: 0 start, 1 busy, 2 standby, 3 page size
   task automatic wait_out(input int sel, input logic lvl, input int lim);
      logic [3:0] v;
      for (int i = 0; i < lim; i++)
      begin
         @(posedge ref_clk);
         #1;
         v = {page_528, standby, busy, prog.start};
         if (v[sel] === lvl)
            return;
      end
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, v[sel], lvl);
      give_verdict();
   endtask
   // ***************************************
   // frames
   // ***************************************
   task automatic head(input logic [7:0] op, input logic [23:0] adr, input logic m3);
      logic [7:0] rx;
      host_model_inst.start_frame(m3);
      host_model_inst.xfer(op, rx);
      for (int i = 2; i >= 0; i--)
         host_model_inst.xfer(adr[i*8+:8], rx);
   endtask
   task automatic cfg(input logic [7:0] op);
      logic [7:0] rx;
      host_model_inst.start_frame(1'b0);
      host_model_inst.xfer(op, rx);
      host_model_inst.end_frame(1'b0);
   endtask
   task automatic wr(input logic [7:0] op, input logic [23:0] adr, input logic [7:0] b,
                     input int n);
      logic [7:0] rx;
      head(op, adr, 1'b0);
      for (int i = 0; i < n; i++)
         host_model_inst.xfer(b + 8'(i), rx);
      host_model_inst.end_frame(1'b0);
   endtask
   task automatic rd(input logic [7:0] op, input logic [23:0] adr, input logic [7:0] b,
                     input int n, input logic m3);
      logic [7:0] rx;
      head(op, adr, m3);
      for (int i = 0; i < n; i++)
      begin
         host_model_inst.xfer(8'h00, rx);
         chk_byte(rx, b + 8'(i));
      end
      chk_bit(so_oe_n, 1'b0);
      host_model_inst.end_frame(m3);
      chk_bit(so_oe_n, 1'b1);
   endtask
   // ***************************************
   // scenarios
   // ***************************************
   task automatic s_reset();
      chk_bit(page_528, PAGE_528_RESET);
      chk_bit(busy, 1'b0);
      chk_bit(overrun, 1'b0);
      chk_bit(so_oe_n, 1'b1);
      chk_prog(prog, '0);
      wait_out(2, 1'b1, 8);
   endtask
   // offset wraps after 528 bytes; read back in both modes
   task automatic s_wrap();
      wr(OPC_WRITE_BUF0, 24'h00_020f, 8'ha5, 3);
      rd(OPC_READ_BUF0, 24'h00_0000, 8'ha6, 2, 1'b1);
      rd(OPC_READ_BUF0, 24'h00_020f, 8'ha5, 1, 1'b0);
   endtask
   task automatic s_512();
      cfg(OPC_CFG_512);
      wait_out(3, 1'b0, 8);
      wr(OPC_WRITE_BUF1, 24'h00_01ff, 8'h3c, 3);
      rd(OPC_READ_BUF1, 24'h00_0000, 8'h3d, 2, 1'b0);
      cfg(OPC_CFG_528);
      wait_out(3, 1'b1, 8);
   endtask
   task automatic s_ignore();
      host_model_inst.noise(32);
      chk_bit(so_oe_n, 1'b1);
      chk_bit(standby, 1'b1);
      rd(OPC_READ_BUF1, 24'h00_0000, 8'h3d, 1, 1'b0);
   endtask
   // last page, then buffer traffic while the array is busy
   task automatic s_program();
      head(OPC_PROG_BUF0, 24'h3f_fc00, 1'b0);
      host_model_inst.end_frame(1'b0);
      // the start pulse is logged on the edge at which end_frame returns
      repeat (2) @(posedge ref_clk);
      chk_prog(last_prog, {1'b1, 1'b0, 12'hfff});
      chk_byte(n_start, 8'h01);
      chk_bit(busy, 1'b1);
      wr(OPC_WRITE_BUF1, 24'h00_0100, 8'h81, 2);
      wr(OPC_WRITE_BUF0, 24'h00_0000, 8'h50, 20);
      chk_bit(overrun, 1'b1);
      chk_bit(standby, 1'b0);
      wait_out(1, 1'b0, 3000);
      wait_out(2, 1'b1, 8);
      rd(OPC_READ_BUF1, 24'h00_0100, 8'h81, 2, 1'b1);
      chk_bit(overrun, 1'b0);
      rd(OPC_READ_BUF0, 24'h00_0000, 8'h50, 1, 1'b0);
   endtask
   initial
   begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      s_reset();
      s_wrap();
      s_512();
      s_ignore();
      s_program();
      give_verdict();
   end
endmodule
`default_nettype wire
